// >>> verilog/dcf_pkg.sv
// Shared constants and types for the block-memory FIFO
package dcf_pkg;

    // ------------------------------------------------------------------
    // Geometry defaults
    // ------------------------------------------------------------------
    localparam int DCF_AW_DEF = 4;
    localparam int DCF_DW_DEF = 8;

    // ------------------------------------------------------------------
    // Memory write behaviours
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DCF_WM_NORMAL,
        DCF_WM_THRU,
        DCF_WM_RBW
    } dcf_wmode_t;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DCF_OFS_CTRL = 8'h00;
    localparam logic [7:0] DCF_OFS_FULL_TH = 8'h04;
    localparam logic [7:0] DCF_OFS_AF_TH = 8'h08;
    localparam logic [7:0] DCF_OFS_AE_TH = 8'h0c;
    localparam logic [7:0] DCF_OFS_STATUS = 8'h10;
    localparam logic [7:0] DCF_OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] DCF_OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] DCF_OFS_IRQ_EN = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DCF_CTRL_CLEAR = 0;
    localparam int DCF_CTRL_REWIND = 1;
    localparam int DCF_CTRL_MODE_LSB = 2;
    localparam int DCF_ST_EMPTY = 0;
    localparam int DCF_ST_AE = 1;
    localparam int DCF_ST_AF = 2;
    localparam int DCF_ST_FULL = 3;
    localparam int DCF_ST_CNT_LSB = 8;
    localparam int DCF_IRQ_OVF = 0;
    localparam int DCF_IRQ_UDF = 1;
    localparam int DCF_IRQ_FULL = 2;
    localparam int DCF_IRQ_EMPTY = 3;
    localparam int DCF_IRQ_W = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam dcf_wmode_t DCF_MODE_RST = DCF_WM_NORMAL;
    localparam int DCF_AF_MARGIN_RST = 1;
    localparam int DCF_AE_TH_RST = 1;
    localparam logic [DCF_IRQ_W-1:0] DCF_IRQ_EN_RST = 4'h0;

endpackage

// >>> verilog/dcf_bram.sv
// Block memory with two ports and selectable write behaviour on port A
`timescale 1ns/1ns
module dcf_bram #(
    parameter int DW = dcf_pkg::DCF_DW_DEF,
    parameter int AW = dcf_pkg::DCF_AW_DEF
) (
    input wire logic clk,
    input wire logic arst_n,
    input dcf_pkg::dcf_wmode_t mode,
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_d,
    output logic [DW-1:0] a_q,
    input wire logic b_en,
    input wire logic [AW-1:0] b_addr,
    output logic [DW-1:0] b_q
);
    import dcf_pkg::*;

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] a_q_next;
    logic [DW-1:0] b_q_next;

    // ------------------------------------------------------------------
    // Output latches
    // ------------------------------------------------------------------
    always_comb begin
        a_q_next = a_q;
        if (a_en) begin
            if (a_we) begin
                unique case (mode)
                    DCF_WM_NORMAL: a_q_next = a_q;
                    DCF_WM_THRU: a_q_next = a_d;
                    DCF_WM_RBW: a_q_next = mem[a_addr];
                    default: a_q_next = a_q;
                endcase
            end else begin
                a_q_next = mem[a_addr];
            end
        end
        // Port B sees the old word on a same-address collision
        b_q_next = b_en ? mem[b_addr] : b_q;
    end

    always_ff @(posedge clk) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_q <= '0;
            b_q <= '0;
        end else begin
            a_q <= a_q_next;
            b_q <= b_q_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_normal_hold;
        @(posedge clk) disable iff (!arst_n)
        a_en && a_we && mode == DCF_WM_NORMAL |=> $stable(a_q);
    endproperty
    a_normal_hold: assert property (p_normal_hold) else $error("normal write moved output");

    property p_write_thru;
        @(posedge clk) disable iff (!arst_n)
        a_en && a_we && mode == DCF_WM_THRU |=> a_q == $past(a_d);
    endproperty
    a_write_thru: assert property (p_write_thru) else $error("write-through word missing");

    property p_read_before;
        @(posedge clk) disable iff (!arst_n)
        a_en && a_we && mode == DCF_WM_RBW |=> a_q == $past(mem[a_addr]);
    endproperty
    a_read_before: assert property (p_read_before) else $error("old contents not shown");

endmodule

// >>> verilog/dcf_fifo.sv
// Block-memory FIFO with push and pop ports, flags and a Wishbone register file
`timescale 1ns/1ns
module dcf_fifo #(
    parameter int DW = dcf_pkg::DCF_DW_DEF,
    parameter int AW = dcf_pkg::DCF_AW_DEF
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic push_clock,
    input wire logic push_clock_gate,
    input wire logic push_strobe,
    input wire logic [DW-1:0] push_data,
    output logic [DW-1:0] push_echo,
    input wire logic pop_clock,
    input wire logic pop_clock_gate,
    input wire logic pop_strobe,
    output logic [DW-1:0] pop_data,
    output logic pop_valid,
    output logic full_flag,
    output logic almost_full_flag,
    output logic almost_empty_flag,
    output logic empty_flag,
    output logic irq
);
    import dcf_pkg::*;

    if (AW < 2 || AW > 16 || DW < 1 || DW > 32) begin : g_bad_geometry
        $error("dcf_fifo: AW must be 2..16 and DW 1..32");
    end

    localparam int PW = DW + 3;
    localparam logic [AW-1:0] TH_MAX = '1;

    // ------------------------------------------------------------------
    // Pin synchronisers and clock edge detection
    // ------------------------------------------------------------------
    logic [PW-1:0] psh_meta;
    logic [PW-1:0] psh_sync;
    logic psh_clk_d;
    logic [2:0] pop_meta;
    logic [2:0] pop_sync;
    logic pop_clk_d;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            psh_meta <= '0;
            psh_sync <= '0;
            psh_clk_d <= 1'b0;
            pop_meta <= '0;
            pop_sync <= '0;
            pop_clk_d <= 1'b0;
        end else begin
            psh_meta <= {push_clock, push_clock_gate, push_strobe, push_data};
            psh_sync <= psh_meta;
            psh_clk_d <= psh_sync[PW-1];
            pop_meta <= {pop_clock, pop_clock_gate, pop_strobe};
            pop_sync <= pop_meta;
            pop_clk_d <= pop_sync[2];
        end
    end

    logic push_tick;
    logic pop_tick;
    logic push_req;
    logic pop_req;
    logic [DW-1:0] push_word;

    assign push_tick = psh_sync[PW-1] && !psh_clk_d;
    assign pop_tick = pop_sync[2] && !pop_clk_d;
    assign push_req = push_tick && psh_sync[PW-2] && psh_sync[PW-3];
    assign pop_req = pop_tick && pop_sync[1] && pop_sync[0];
    assign push_word = psh_sync[DW-1:0];

    // ------------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------------
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    dcf_wmode_t mode_reg, mode_next;
    logic [AW-1:0] full_th_reg, full_th_next;
    logic [AW-1:0] af_th_reg, af_th_next;
    logic [AW-1:0] ae_th_reg, ae_th_next;
    logic [DCF_IRQ_W-1:0] ist_reg, ist_next;
    logic [DCF_IRQ_W-1:0] ien_reg, ien_next;
    logic irq_reg, irq_next;
    logic clear_cmd;
    logic rewind_cmd;

    // ------------------------------------------------------------------
    // FIFO state
    // ------------------------------------------------------------------
    logic [AW-1:0] wptr_reg, wptr_next;
    logic [AW-1:0] rptr_reg, rptr_next;
    logic [AW-1:0] cnt_next;
    logic full_reg, full_next;
    logic af_reg, af_next;
    logic ae_reg, ae_next;
    logic empty_reg, empty_next;
    logic pop_valid_reg, pop_valid_next;
    logic push_ok;
    logic pop_ok;

    assign push_ok = push_req && !full_reg;
    assign pop_ok = pop_req && !empty_reg && !rewind_cmd;

    always_comb begin
        wptr_next = wptr_reg + AW'(push_ok);
        rptr_next = rewind_cmd ? '0 : rptr_reg + AW'(pop_ok);
        cnt_next = wptr_next - rptr_next;
        full_next = full_reg;
        af_next = af_reg;
        ae_next = ae_reg;
        empty_next = empty_reg;
        pop_valid_next = pop_ok && !clear_cmd;
        if (push_tick) begin
            full_next = cnt_next >= full_th_reg;
            af_next = cnt_next >= af_th_reg;
        end
        if (pop_tick) begin
            empty_next = cnt_next == '0;
            ae_next = cnt_next <= ae_th_reg;
        end
        if (clear_cmd) begin
            wptr_next = '0;
            rptr_next = '0;
            full_next = 1'b0;
            af_next = 1'b0;
            ae_next = 1'b1;
            empty_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            full_reg <= 1'b0;
            af_reg <= 1'b0;
            ae_reg <= 1'b1;
            empty_reg <= 1'b1;
            pop_valid_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            full_reg <= full_next;
            af_reg <= af_next;
            ae_reg <= ae_next;
            empty_reg <= empty_next;
            pop_valid_reg <= pop_valid_next;
        end
    end

    // ------------------------------------------------------------------
    // Block memory: port A writes, port B reads
    // ------------------------------------------------------------------
    dcf_bram #(
        .DW(DW),
        .AW(AW)
    ) u_block_memory (
        .clk(mclk),
        .arst_n(arst_n),
        .mode(mode_reg),
        .a_en(push_ok),
        .a_we(push_ok),
        .a_addr(wptr_reg),
        .a_d(push_word),
        .a_q(push_echo),
        .b_en(pop_ok),
        .b_addr(rptr_reg),
        .b_q(pop_data)
    );

    // ------------------------------------------------------------------
    // Wishbone slave and interrupts
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction

    logic wr_go;
    logic [31:0] wval;
    logic [AW-1:0] th_val;
    logic [DCF_IRQ_W-1:0] ev;
    logic [DCF_IRQ_W-1:0] clr_mask;
    logic [31:0] rdata;

    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign wval = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    assign th_val = wval[AW-1:0];
    assign clear_cmd = wr_go && wb_adr_i == DCF_OFS_CTRL && wval[DCF_CTRL_CLEAR];
    assign rewind_cmd = wr_go && wb_adr_i == DCF_OFS_CTRL && wval[DCF_CTRL_REWIND];
    assign clr_mask = (wr_go && wb_adr_i == DCF_OFS_IRQ_CLR) ? wval[DCF_IRQ_W-1:0] : '0;

    always_comb begin
        ev = '0;
        ev[DCF_IRQ_OVF] = push_req && full_reg;
        ev[DCF_IRQ_UDF] = pop_req && empty_reg;
        ev[DCF_IRQ_FULL] = full_next && !full_reg;
        ev[DCF_IRQ_EMPTY] = empty_next && !empty_reg;
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            DCF_OFS_CTRL: rdata[DCF_CTRL_MODE_LSB +: 2] = mode_reg;
            DCF_OFS_FULL_TH: rdata[AW-1:0] = full_th_reg;
            DCF_OFS_AF_TH: rdata[AW-1:0] = af_th_reg;
            DCF_OFS_AE_TH: rdata[AW-1:0] = ae_th_reg;
            DCF_OFS_STATUS: begin
                rdata[DCF_ST_EMPTY] = empty_reg;
                rdata[DCF_ST_AE] = ae_reg;
                rdata[DCF_ST_AF] = af_reg;
                rdata[DCF_ST_FULL] = full_reg;
                rdata[DCF_ST_CNT_LSB +: AW] = wptr_reg - rptr_reg;
            end
            DCF_OFS_IRQ_STAT: rdata[DCF_IRQ_W-1:0] = ist_reg;
            DCF_OFS_IRQ_EN: rdata[DCF_IRQ_W-1:0] = ien_reg;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        dat_next = ack_next ? rdata : dat_reg;
        mode_next = mode_reg;
        full_th_next = full_th_reg;
        af_th_next = af_th_reg;
        ae_th_next = ae_th_reg;
        ien_next = ien_reg;
        if (wr_go) begin
            unique case (wb_adr_i)
                DCF_OFS_CTRL: mode_next = dcf_wmode_t'(wval[DCF_CTRL_MODE_LSB +: 2]);
                DCF_OFS_FULL_TH: if (th_val != '0) full_th_next = th_val;
                DCF_OFS_AF_TH: if (th_val != '0 && th_val < full_th_reg) af_th_next = th_val;
                DCF_OFS_AE_TH: if (th_val != '0 && th_val < full_th_reg) ae_th_next = th_val;
                DCF_OFS_IRQ_EN: ien_next = wval[DCF_IRQ_W-1:0];
                default: ;
            endcase
        end
        // A new event wins over a clear in the same cycle
        ist_next = (ist_reg & ~clr_mask) | ev;
        irq_next = |(ist_next & ien_next);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            mode_reg <= DCF_MODE_RST;
            full_th_reg <= TH_MAX;
            af_th_reg <= TH_MAX - AW'(DCF_AF_MARGIN_RST);
            ae_th_reg <= AW'(DCF_AE_TH_RST);
            ist_reg <= '0;
            ien_reg <= DCF_IRQ_EN_RST;
            irq_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            mode_reg <= mode_next;
            full_th_reg <= full_th_next;
            af_th_reg <= af_th_next;
            ae_th_reg <= ae_th_next;
            ist_reg <= ist_next;
            ien_reg <= ien_next;
            irq_reg <= irq_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign full_flag = full_reg;
    assign almost_full_flag = af_reg;
    assign almost_empty_flag = ae_reg;
    assign empty_flag = empty_reg;
    assign pop_valid = pop_valid_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    property p_full_push_domain;
        !push_tick && !clear_cmd |=> $stable(full_reg) && $stable(af_reg);
    endproperty
    a_full_push_domain: assert property (p_full_push_domain) else $error("full moved off push edge");

    property p_empty_pop_domain;
        !pop_tick && !clear_cmd |=> $stable(empty_reg) && $stable(ae_reg);
    endproperty
    a_empty_pop_domain: assert property (p_empty_pop_domain) else $error("empty moved off pop edge");

    property p_full_level;
        push_tick && !clear_cmd |=> full_reg == ((wptr_reg - rptr_reg) >= $past(full_th_reg));
    endproperty
    a_full_level: assert property (p_full_level) else $error("full level wrong");

    property p_af_level;
        push_tick && !clear_cmd |=> af_reg == ((wptr_reg - rptr_reg) >= $past(af_th_reg));
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost full level wrong");

    property p_empty_level;
        pop_tick && !clear_cmd |=> empty_reg == (wptr_reg == rptr_reg);
    endproperty
    a_empty_level: assert property (p_empty_level) else $error("empty level wrong");

    property p_clear;
        clear_cmd |=> wptr_reg == '0 && rptr_reg == '0 && empty_reg && ae_reg && !full_reg && !af_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left state behind");

    property p_rewind;
        rewind_cmd && !clear_cmd && !push_tick |=> rptr_reg == '0 && $stable(wptr_reg);
    endproperty
    a_rewind: assert property (p_rewind) else $error("rewind did not act alone");

    property p_no_overrun;
        push_tick && full_reg && !clear_cmd |=> $stable(wptr_reg);
    endproperty
    a_no_overrun: assert property (p_no_overrun) else $error("push while full moved pointer");

    property p_th_range;
        full_th_reg != '0 && af_th_reg != '0 && ae_th_reg != '0;
    endproperty
    a_th_range: assert property (p_th_range) else $error("threshold reached zero");

endmodule

// >>> sim/dcf_user_model.sv
// User-side model that pushes and pops words through the FIFO pins
`timescale 1ns/1ns
module dcf_user_model #(
    parameter int DW = 8
) (
    input wire logic mclk,
    output logic push_clock,
    output logic push_clock_gate,
    output logic push_strobe,
    output logic [DW-1:0] push_data,
    output logic pop_clock,
    output logic pop_clock_gate,
    output logic pop_strobe,
    input wire logic [DW-1:0] pop_data,
    input wire logic pop_valid
);
    initial begin
        push_clock = 1'h0;
        push_clock_gate = 1'h0;
        push_strobe = 1'h0;
        push_data = '0;
        pop_clock = 1'h0;
        pop_clock_gate = 1'h0;
        pop_strobe = 1'h0;
    end

    // Pin clocks are slow against mclk: 3 cycles setup, 4 high on push and 6 on pop, 3 low
    task automatic push_word(input logic [DW-1:0] d, input logic req);
        @(posedge mclk);
        push_data <= d;
        push_clock_gate <= 1'h1;
        push_strobe <= req;
        repeat (3) @(posedge mclk);
        push_clock <= 1'h1;
        repeat (4) @(posedge mclk);
        push_clock <= 1'h0;
        repeat (3) @(posedge mclk);
        push_clock_gate <= 1'h0;
        push_strobe <= 1'h0;
        push_data <= ~d;
    endtask

    // A request of 0 still gives a pop edge, which refreshes the reader flags
    task automatic pop_word(input logic req, output logic [DW-1:0] d, output logic got);
        got = 1'h0;
        d = '0;
        @(posedge mclk);
        pop_clock_gate <= 1'h1;
        pop_strobe <= req;
        repeat (3) @(posedge mclk);
        pop_clock <= 1'h1;
        repeat (6) begin
            @(posedge mclk);
            if (pop_valid === 1'h1) begin
                got = 1'h1;
                d = pop_data;
            end
        end
        pop_clock <= 1'h0;
        repeat (3) @(posedge mclk);
        pop_clock_gate <= 1'h0;
        pop_strobe <= 1'h0;
    endtask
endmodule

// >>> sim/dcf_fifo_tb.sv
// Testbench for the block-memory FIFO: register accesses and push/pop sequences
`timescale 1ns/1ns
module dcf_fifo_tb;
    import dcf_pkg::*;
    localparam int FTH = 4;
    localparam int AFT = 3;
    localparam int AET = 2;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, pclk, pgate, pstb, qclk, qgate, qstb, pvalid, ff, aff, aef, ef, irq, got;
    logic [7:0] pdata, echo, qdata, d;
    logic [7:0] ra [7] = '{DCF_OFS_CTRL, DCF_OFS_FULL_TH, DCF_OFS_AF_TH, DCF_OFS_AE_TH,
        DCF_OFS_STATUS, DCF_OFS_IRQ_EN, 8'h20};
    logic [31:0] rv [7] = '{32'h0, 32'hf, 32'he, 32'h1, 32'h3, 32'h0, 32'h0};
    logic [1:0] md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [7:0] mdd [4] = '{8'h5a, 8'hc3, 8'h77, 8'h88};
    logic [7:0] mde [4] = '{8'h5a, 8'h22, 8'h22, 8'h22};
    int errors = 0, n_compared = 0, cycles = 0;

    always #50 mclk = ~mclk;

    dcf_fifo #(.DW(8), .AW(4)) uut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .push_clock(pclk), .push_clock_gate(pgate),
        .push_strobe(pstb), .push_data(pdata), .push_echo(echo), .pop_clock(qclk),
        .pop_clock_gate(qgate), .pop_strobe(qstb), .pop_data(qdata), .pop_valid(pvalid),
        .full_flag(ff), .almost_full_flag(aff), .almost_empty_flag(aef), .empty_flag(ef),
        .irq(irq));

    dcf_user_model #(.DW(8)) usr (.mclk(mclk), .push_clock(pclk), .push_clock_gate(pgate),
        .push_strobe(pstb), .push_data(pdata), .pop_clock(qclk), .pop_clock_gate(qgate),
        .pop_strobe(qstb), .pop_data(qdata), .pop_valid(pvalid));

    task summarize;
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e, input string what);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask

    // Classic single cycle; cyc and stb drop for a cycle between accesses
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= v;
        @(posedge mclk);
        while (ack !== 1'h1) @(posedge mclk);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk(q, e, "register read");
    endtask

    task push_chk(input logic [7:0] v, input int cnt);
        usr.push_word(v, 1'h1);
        chk({ff, aff}, {cnt >= FTH, cnt >= AFT}, "writer flags");
        chk(ef, 1'h1, "empty waits for a pop edge");
    endtask

    task pop_chk(input logic [7:0] v, input int cnt);
        usr.pop_word(1'h1, d, got);
        chk(got, 1'h1, "pop taken");
        chk(d, v, "pop data");
        chk({aef, ef}, {cnt <= AET, cnt == 0}, "reader flags");
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'h1;
        repeat (4) @(posedge mclk);
        chk({ff, aff, aef, ef}, 4'h3, "flags after reset");
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
        wb(1'h1, DCF_OFS_FULL_TH, 32'h0);
        rd(DCF_OFS_FULL_TH, 32'hf);
        wb(1'h1, DCF_OFS_FULL_TH, FTH);
        wb(1'h1, DCF_OFS_AF_TH, FTH);
        rd(DCF_OFS_AF_TH, 32'he);
        wb(1'h1, DCF_OFS_AF_TH, AFT);
        wb(1'h1, DCF_OFS_AE_TH, AET);
        rd(DCF_OFS_AF_TH, AFT);
        wb(1'h1, DCF_OFS_IRQ_EN, 32'hf);
        for (int i = 1; i <= 4; i++) push_chk(8'(8'h11 * i), i);
        chk(irq, 1'h1, "irq on full");
        usr.push_word(8'h99, 1'h1);
        rd(DCF_OFS_STATUS, 32'h40f);
        rd(DCF_OFS_IRQ_STAT, 32'h5);
        wb(1'h1, DCF_OFS_IRQ_CLR, 32'h5);
        rd(DCF_OFS_IRQ_STAT, 32'h0);
        chk(irq, 1'h0, "irq after clear");
        usr.pop_word(1'h0, d, got);
        chk({got, aef, ef}, 3'h0, "idle pop edge refreshes");
        pop_chk(8'h11, 3);
        pop_chk(8'h22, 2);
        chk(ff, 1'h1, "full waits for a push edge");
        wb(1'h1, DCF_OFS_CTRL, 32'h2);
        for (int i = 1; i <= 4; i++) pop_chk(8'(8'h11 * i), 4 - i);
        usr.pop_word(1'h1, d, got);
        chk(got, 1'h0, "pop while empty");
        rd(DCF_OFS_IRQ_STAT, 32'ha);
        chk(irq, 1'h1, "irq on empty");
        wb(1'h1, DCF_OFS_IRQ_EN, 32'h0);
        rd(DCF_OFS_IRQ_STAT, 32'ha);
        chk(irq, 1'h0, "irq masked");
        wb(1'h1, DCF_OFS_IRQ_CLR, 32'hf);
        rd(DCF_OFS_IRQ_STAT, 32'h0);
        wb(1'h1, DCF_OFS_CTRL, 32'h1);
        rd(DCF_OFS_STATUS, 32'h3);
        chk({ff, aff, aef, ef}, 4'h3, "flags after clear");
        for (int i = 0; i < 4; i++) begin
            wb(1'h1, DCF_OFS_CTRL, {28'h0, md[i], 2'h0});
            rd(DCF_OFS_CTRL, {28'h0, md[i], 2'h0});
            usr.push_word(mdd[i], 1'h1);
            chk(echo, mde[i], "write port output");
        end
        usr.pop_word(1'h0, d, got);
        for (int i = 0; i < 4; i++) pop_chk(mdd[i], 3 - i);
        summarize();
    end
endmodule
